/* shared/ctd_pkg.sv */
// Package of constants, types and decoders for the current trip and diagnostic block.
package ctd_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 10;
	localparam int OFF_STEP_US      = 10;
	localparam int OFF_STEP_CYC     = (OFF_STEP_US * 1000) / CLK_PERIOD_NS;
	localparam int HW_OFF_TIME_US   = 30;
	localparam int SER_OFF_BASE_US  = 20;
	localparam int BLANK_TIME_NS    = 2000;
	localparam int BLANK_CYC        = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W            = 16;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] OFS_CONFIG_TWO   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CONFIG_THREE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS_ONE   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_COMMAND      = 8'h0C;

	localparam int CFG2_DIAGNOSTIC_SELECT_LSB  = 0;
	localparam int CFG3_TRIP_LSB  = 0;
	localparam int CFG3_FIXED_OFF_TIME_LSB  = 4;
	localparam int STS_TRIP_BIT   = 0;
	localparam int STS_FAULT_BIT  = 1;
	localparam int STS_STATE_LSB  = 2;
	localparam int CMD_CLR_BIT    = 0;

	localparam logic [1:0] DIAGNOSTIC_SELECT_RESET = 2'h0;
	localparam logic [2:0] TRIP_RESET = 3'h0;
	localparam logic [1:0] FIXED_OFF_TIME_RESET = 2'h1;
	localparam logic [2:0] TRIP_OFF   = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		ST_SLEEP   = 2'b00,
		ST_STANDBY = 2'b01,
		ST_ACTIVE  = 2'b10
	} ctd_state_e;

	typedef struct packed
	{
		logic       sleep_request_n;
		logic       output_disable;
		logic       drive_in;
		logic       sense_valid;
		logic       slewing;
		logic       trip_cmp;
		logic       fault_detect;
		logic [2:0] trip_level_pin;
		logic [2:0] diagnostic_select;
	} ctd_pins_s;

	typedef struct packed
	{
		logic off_state_load_check;
		logic on_state_open_load_check;
		logic fault_latch;
		logic trip_available;
	} ctd_diagnostic_select_s;

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	function automatic ctd_diagnostic_select_s ctd_decode_pin_diagnostic_select(input logic [2:0] lvl);
		ctd_diagnostic_select_s d;
		d = '{default: 1'b0};
		case (lvl)
			3'h0:    d = '{1'b0, 1'b0, 1'b0, 1'b1};
			3'h1:    d = '{1'b1, 1'b0, 1'b1, 1'b1};
			3'h2:    d = '{1'b1, 1'b0, 1'b1, 1'b0};
			3'h3:    d = '{1'b1, 1'b0, 1'b0, 1'b0};
			3'h4:    d = '{1'b0, 1'b0, 1'b1, 1'b1};
			default: d = '{1'b1, 1'b0, 1'b0, 1'b1};
		endcase
		return d;
	endfunction

	function automatic ctd_diagnostic_select_s ctd_decode_ser_diagnostic_select(input logic [1:0] code);
		ctd_diagnostic_select_s d;
		d = '{default: 1'b0};
		case (code)
			2'h0:    d = '{1'b0, 1'b0, 1'b0, 1'b1};
			2'h1:    d = '{1'b1, 1'b0, 1'b0, 1'b1};
			2'h2:    d = '{1'b0, 1'b1, 1'b0, 1'b0};
			default: d = '{1'b1, 1'b1, 1'b0, 1'b0};
		endcase
		return d;
	endfunction

	function automatic logic [2:0] ctd_pin_trip_code(input logic [2:0] lvl);
		logic [2:0] c;
		c = 3'h0;
		case (lvl)
			3'h0:    c = 3'h0;
			3'h1:    c = 3'h1;
			3'h2:    c = 3'h4;
			3'h3:    c = 3'h5;
			3'h4:    c = 3'h6;
			default: c = 3'h7;
		endcase
		return c;
	endfunction

endpackage

/* verilog/ctd_trip_diagnostic_select.sv */
// Current trip regulation, diagnostic select decode and fault pin control.
//
// Contract
// - Off-time 30 us strapped, 20 to 50 us serial.
// - Trip works only with high side on, sensing valid.
// - Sense above reference forces output low for off-time.
// - Input change ends forced-low interval at once.
// - Comparator ignored while output slews.
// - Extra blanking after leaving low-side recirculation.
// - Trip code zero disables, others ascend; pins six.
// - Strapped trip level pin is transparent.
// - Serial trip field writable anytime, immediate effect.
// - Serial trip flag sets silently, cleared by command.
// - High-side diagnostic setting masks trip regulation.
// - Low-side serial setting masks on-state open-load check.
// - Six-level diagnostic pin decode table.
// - Diagnostic pin sampled once at initialization.
// - Two-bit serial diagnostic field decode table.
// - Serial diagnostic field writable anytime, immediate.
// - Fault pulls open-drain fault output low.
// - Sleep entry releases fault output.
// - State follows sleep and disable inputs.
// - Serial flags clear on command or sleep only.
`timescale 1ns/10ps

module ctd_trip_diagnostic_select
#(
	parameter bit              SERIAL_VARIANT = 1'b1,
	parameter int unsigned     OFF_STEP_CYCLES = ctd_pkg::OFF_STEP_CYC
)
(
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       arst_n,
	// Device pins, asynchronous
	input  wire ctd_pkg::ctd_pins_s         pins,
	// Register port
	input  wire logic [ctd_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ctd_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic [ctd_pkg::DATA_W-1:0]      reg_rdata,
	// Half-bridge drive
	output logic                            high_side_switch,
	output logic                            low_side_switch,
	output logic [2:0]                      trip_reference_sel,
	// Decoded diagnostic configuration
	output ctd_pkg::ctd_diagnostic_select_s              diagnostic_select_cfg,
	// Open-drain fault pin
	output logic                            fault_output_n_o,
	output logic                            fault_output_n_oe
);
	import ctd_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = $bits(ctd_pins_s);

	logic [PIN_W-1:0] sync1_reg;
	logic [PIN_W-1:0] sync2_reg;
	ctd_pins_s        pin_s;

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++)
		begin : g_sync
			always_ff @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end
				else
				begin
					sync1_reg[gi] <= pins[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	assign pin_s = ctd_pins_s'(sync2_reg);

	// ----------------------------------------------------------------
	// Device state
	// ----------------------------------------------------------------
	ctd_state_e state_reg;
	ctd_state_e state_next;

	always_comb
	begin
		if (!pin_s.sleep_request_n)
			state_next = ST_SLEEP;
		else if (pin_s.output_disable)
			state_next = ST_STANDBY;
		else
			state_next = ST_ACTIVE;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= ST_SLEEP;
		else
			state_reg <= state_next;
	end

	logic sleep_entry;
	assign sleep_entry = (state_next == ST_SLEEP) && (state_reg != ST_SLEEP);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [1:0] diagnostic_select_field_reg;
	logic [2:0] trip_field_reg;
	logic [1:0] off_time_select_reg;
	logic       clear_fault_command;

	assign clear_fault_command = reg_wr && (reg_addr == OFS_COMMAND) && reg_wdata[CMD_CLR_BIT];

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			diagnostic_select_field_reg <= DIAGNOSTIC_SELECT_RESET;
			trip_field_reg <= TRIP_RESET;
			off_time_select_reg   <= FIXED_OFF_TIME_RESET;
		end
		else if (reg_wr && (reg_addr == OFS_CONFIG_TWO))
			diagnostic_select_field_reg <= reg_wdata[CFG2_DIAGNOSTIC_SELECT_LSB +: 2];
		else if (reg_wr && (reg_addr == OFS_CONFIG_THREE))
		begin
			trip_field_reg <= reg_wdata[CFG3_TRIP_LSB +: 3];
			off_time_select_reg   <= reg_wdata[CFG3_FIXED_OFF_TIME_LSB +: 2];
		end
	end

	// ----------------------------------------------------------------
	// Diagnostic select
	// ----------------------------------------------------------------
	// The strapped level is held across operation so a noisy pin cannot
	// change the fault reaction mid-run.
	logic       init_pending_reg;
	logic [2:0] diagnostic_select_pin_latch_reg;
	ctd_diagnostic_select_s  diagnostic_select_now;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			init_pending_reg   <= 1'b1;
			diagnostic_select_pin_latch_reg <= 3'h0;
		end
		else if (state_reg == ST_SLEEP)
			init_pending_reg <= 1'b1;
		else if (init_pending_reg)
		begin
			init_pending_reg   <= 1'b0;
			diagnostic_select_pin_latch_reg <= pin_s.diagnostic_select;
		end
	end

	always_comb
	begin
		if (SERIAL_VARIANT)
			diagnostic_select_now = ctd_decode_ser_diagnostic_select(diagnostic_select_field_reg);
		else
			diagnostic_select_now = ctd_decode_pin_diagnostic_select(diagnostic_select_pin_latch_reg);
	end

	// ----------------------------------------------------------------
	// Trip level
	// ----------------------------------------------------------------
	logic [2:0] trip_code;
	logic       trip_enabled;

	assign trip_code = SERIAL_VARIANT ? trip_field_reg
	                                  : ctd_pin_trip_code(pin_s.trip_level_pin);
	assign trip_enabled = (trip_code != TRIP_OFF) && diagnostic_select_now.trip_available;

	// ----------------------------------------------------------------
	// Blanking and off-time counters
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] off_len;
	logic [CNT_W-1:0] off_cnt_reg;
	logic [CNT_W-1:0] blank_cnt_reg;
	logic             prev_drive_reg;
	logic             prev_disable_reg;
	logic             prev_ls_reg;
	logic             in_off;
	logic             hs_commanded;
	logic             input_change;
	logic             trip_valid;
	logic             trip_fire;

	always_comb
	begin
		if (SERIAL_VARIANT)
			off_len = CNT_W'((SER_OFF_BASE_US / OFF_STEP_US + int'(off_time_select_reg))
			          * OFF_STEP_CYCLES);
		else
			off_len = CNT_W'((HW_OFF_TIME_US / OFF_STEP_US) * OFF_STEP_CYCLES);
	end

	assign in_off       = (off_cnt_reg != '0);
	assign hs_commanded = (state_reg == ST_ACTIVE) && pin_s.drive_in;
	assign input_change = (pin_s.drive_in != prev_drive_reg)
	                   || (pin_s.output_disable != prev_disable_reg);
	assign trip_valid   = trip_enabled && hs_commanded && pin_s.sense_valid
	                   && !pin_s.slewing
	                   && (blank_cnt_reg == '0);
	assign trip_fire    = trip_valid && pin_s.trip_cmp && !in_off && !input_change;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prev_drive_reg   <= 1'b0;
			prev_disable_reg <= 1'b0;
		end
		else
		begin
			prev_drive_reg   <= pin_s.drive_in;
			prev_disable_reg <= pin_s.output_disable;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			off_cnt_reg <= '0;
		else if (input_change || !hs_commanded)
			off_cnt_reg <= '0;
		else if (trip_fire)
			// The output flop adds a cycle, so the count stops one short.
			off_cnt_reg <= off_len - CNT_W'(1);
		else if (in_off)
			off_cnt_reg <= off_cnt_reg - CNT_W'(1);
	end

	// Blanking restarts whenever the high side takes over from low-side
	// recirculation, including the end of a forced-low interval.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			blank_cnt_reg <= '0;
		else if (hs_commanded && !in_off && prev_ls_reg)
			blank_cnt_reg <= CNT_W'(BLANK_CYC);
		else if (blank_cnt_reg != '0)
			blank_cnt_reg <= blank_cnt_reg - CNT_W'(1);
	end

	// ----------------------------------------------------------------
	// Bridge outputs
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			high_side_switch   <= 1'b0;
			low_side_switch    <= 1'b0;
			prev_ls_reg        <= 1'b0;
			trip_reference_sel <= 3'h0;
			diagnostic_select_cfg           <= '{default: 1'b0};
		end
		else
		begin
			high_side_switch   <= hs_commanded && !in_off && !trip_fire;
			low_side_switch    <= (state_reg == ST_ACTIVE) && (!pin_s.drive_in || in_off
			                      || trip_fire);
			prev_ls_reg        <= (state_reg == ST_ACTIVE) && low_side_switch;
			trip_reference_sel <= trip_code;
			diagnostic_select_cfg           <= diagnostic_select_now;
		end
	end

	// ----------------------------------------------------------------
	// Status flags and fault pin
	// ----------------------------------------------------------------
	// A set and a clear in the same cycle keep the flag, so no event is lost.
	logic trip_flag_reg;
	logic fault_flag_reg;

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trip_flag_reg  <= 1'b0;
			fault_flag_reg <= 1'b0;
		end
		else
		begin
			if (SERIAL_VARIANT && trip_fire)
				trip_flag_reg <= 1'b1;
			else if (clear_fault_command || sleep_entry)
				trip_flag_reg <= 1'b0;
			if (pin_s.fault_detect && (state_reg != ST_SLEEP))
				fault_flag_reg <= 1'b1;
			else if (clear_fault_command || sleep_entry)
				fault_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fault_output_n_o  <= 1'b0;
			fault_output_n_oe <= 1'b0;
		end
		else
		begin
			fault_output_n_o  <= 1'b0;
			if (state_next == ST_SLEEP)
				fault_output_n_oe <= 1'b0;
			else if (SERIAL_VARIANT)
				fault_output_n_oe <= fault_flag_reg || pin_s.fault_detect;
			else
				fault_output_n_oe <= pin_s.fault_detect;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else
		begin
			case (reg_addr)
				OFS_CONFIG_TWO:   reg_rdata <= DATA_W'(diagnostic_select_field_reg);
				OFS_CONFIG_THREE: reg_rdata <= DATA_W'({off_time_select_reg, 1'b0, trip_field_reg});
				OFS_STATUS_ONE:   reg_rdata <= DATA_W'({state_reg, fault_flag_reg, trip_flag_reg});
				default:          reg_rdata <= '0;
			endcase
		end
	end

endmodule

/* test/ctd_trip_diagnostic_select_checker.sv */
// Port checker of the current trip and diagnostic block.
`timescale 1ns/10ps
module ctd_trip_diagnostic_select_checker
	import ctd_pkg::*;
#(
	parameter bit          SERIAL_VARIANT  = 1'b1,
	parameter int unsigned OFF_STEP_CYCLES = OFF_STEP_CYC
)
(
	// Clock and reset
	input wire logic                       mclk,
	input wire logic                       arst_n,
	// Inputs
	input wire ctd_pkg::ctd_pins_s         pins,
	input wire logic [ctd_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ctd_pkg::DATA_W-1:0] reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	// Outputs
	input wire logic [ctd_pkg::DATA_W-1:0] reg_rdata,
	input wire logic                       high_side_switch,
	input wire logic                       low_side_switch,
	input wire logic [2:0]                 trip_reference_sel,
	input wire ctd_pkg::ctd_diagnostic_select_s         diagnostic_select_cfg,
	input wire logic                       fault_output_n_o,
	input wire logic                       fault_output_n_oe
);
	logic        act_hi;
	logic [15:0] since_lo;

	assign act_hi = pins.sleep_request_n & ~pins.output_disable & pins.drive_in;

	// Saturating count of cycles since the low side last conducted.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			since_lo <= 16'hFFFF;
		else if (low_side_switch)
			since_lo <= 16'h0000;
		else if (since_lo != 16'hFFFF)
			since_lo <= since_lo + 16'h0001;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	no_shoot_a: assert property (!(high_side_switch && low_side_switch))
		else $error("both switches on");
	sleep_hiz_a: assert property (!pins.sleep_request_n [*5]
		|-> !high_side_switch && !low_side_switch && !fault_output_n_oe)
		else $error("sleep not quiet");
	low_follow_a: assert property ((pins.sleep_request_n && !pins.output_disable
		&& !pins.drive_in) [*5] |-> low_side_switch && !high_side_switch)
		else $error("output not low");
	fault_pull_a: assert property ((pins.fault_detect && pins.sleep_request_n) [*5]
		|-> fault_output_n_oe && !fault_output_n_o)
		else $error("fault line not pulled");
	trip_cause_a: assert property (act_hi [*6] ##0 $fell(high_side_switch)
		|-> $past(diagnostic_select_cfg.trip_available) && $past(trip_reference_sel) != 3'h0
		&& ($past(pins.trip_cmp, 2) || $past(pins.trip_cmp, 3) || $past(pins.trip_cmp, 4)))
		else $error("trip without cause");
	blank_time_a: assert property (act_hi [*6] ##0 $fell(high_side_switch)
		|-> $past(since_lo) >= BLANK_CYC - 2)
		else $error("trip inside blanking");
	trip_write_a: assert property (SERIAL_VARIANT && reg_wr
		&& reg_addr == OFS_CONFIG_THREE |-> ##2 trip_reference_sel == $past(reg_wdata[2:0], 2))
		else $error("trip level not applied");
	diagnostic_select_write_a: assert property (reg_wr && reg_addr == OFS_CONFIG_TWO
		&& reg_wdata[1:0] == 2'h2 && SERIAL_VARIANT |-> ##2 !diagnostic_select_cfg.trip_available)
		else $error("diagnostic_select mask not applied");
	hs_drop_a: assert property ($rose(pins.output_disable) && pins.sleep_request_n
		|-> ##[1:5] !high_side_switch && !low_side_switch)
		else $error("disable ignored");

	cover property ($fell(high_side_switch) && act_hi);
	cover property (pins.slewing && pins.trip_cmp);
	cover property (fault_output_n_oe && !pins.fault_detect);
endmodule

/* test/ctd_host_model.sv */
// Host side model driving the device pins and the sense comparator.
`timescale 1ns/10ps
module ctd_host_model
(
	// Clock and bridge feedback
	input wire logic           mclk,
	input wire logic           high_side_switch,
	// Pins toward the device
	output ctd_pkg::ctd_pins_s pins
);
	import ctd_pkg::*;
	ctd_pins_s ctl = '0;
	logic      over = 1'b0;

	// The sensed current only exists while the high side conducts.
	always_comb
	begin
		pins = ctl;
		pins.trip_cmp = over & high_side_switch;
	end

	// Pins change right after an edge and then hold.
	task automatic put(input ctd_pins_s v, input logic o);
		@(posedge mclk);
		ctl <= v;
		over <= o;
	endtask
endmodule

/* test/test_current_trip_regulation_diagnostic_select.sv */
// Self-checking bench of the current trip and diagnostic block.
`timescale 1ns/10ps
module test_current_trip_regulation_diagnostic_select;
	import ctd_pkg::*;
	localparam int OFF_CYC = 4;
	logic       mclk;
	logic       arst_n;
	ctd_pins_s  pins;
	ctd_pins_s  p;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       high_side_switch;
	logic       low_side_switch;
	logic [2:0] trip_reference_sel;
	ctd_diagnostic_select_s  diagnostic_select_cfg;
	logic       fault_output_n_o;
	logic       fault_output_n_oe;
	ctd_diagnostic_select_s  diagnostic_select_hw;
	logic [2:0] trip_ref_hw;
	logic [7:0] d;
	logic [7:0] n;
	logic [1:0] sel;
	logic [2:0] code;
	int         k;
	int         error_cnt = 0;
	int         tests_run = 0;

	ctd_trip_diagnostic_select #(.SERIAL_VARIANT(1'b1), .OFF_STEP_CYCLES(OFF_CYC)) dut (.mclk, .arst_n,
		.pins, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .high_side_switch,
		.low_side_switch, .trip_reference_sel, .diagnostic_select_cfg, .fault_output_n_o, .fault_output_n_oe);
	ctd_trip_diagnostic_select #(.SERIAL_VARIANT(1'b0), .OFF_STEP_CYCLES(OFF_CYC)) dut_hw (.mclk, .arst_n,
		.pins, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .high_side_switch(),
		.low_side_switch(), .trip_reference_sel(trip_ref_hw), .diagnostic_select_cfg(diagnostic_select_hw),
		.fault_output_n_o(), .fault_output_n_oe());
	ctd_host_model host (.mclk, .high_side_switch, .pins);

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Bits are off-state check, on-state check, latch, trip available.
	function automatic logic [7:0] exp_diagnostic_select(input logic [1:0] c);
		case (c)
			2'h0:    return 8'h01;
			2'h1:    return 8'h09;
			2'h2:    return 8'h04;
			default: return 8'h0C;
		endcase
	endfunction

	function automatic logic [7:0] exp_off(input logic [1:0] s);
		return 8'((2 + s) * OFF_CYC);
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic wait_hs(input logic v, output logic [7:0] c);
		c = 8'h00;
		while (high_side_switch !== v && c < 8'hFA)
		begin
			cyc(1);
			c++;
		end
		if (high_side_switch !== v)
		begin
			error_cnt++;
			$display("mismatch at %0t: switch wait timed out", $time);
			results();
		end
	endtask

	initial
	begin
		p = '0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		arst_n = 1'b0;
		void'($urandom(50));
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		rd(OFS_CONFIG_THREE, d);
		chk(d, 8'h10);
		rd(8'h20, d);
		chk(d, 8'h00);
		for (k = 0; k < 4; k++)
		begin
			wr(OFS_CONFIG_TWO, 8'(k));
			cyc(3);
			chk({4'h0, diagnostic_select_cfg}, exp_diagnostic_select(2'(k)));
		end
		wr(OFS_CONFIG_TWO, 8'h00);
		p.sleep_request_n = 1'b1;
		p.sense_valid = 1'b1;
		p.diagnostic_select = 3'h2;
		p.trip_level_pin = 3'h3;
		host.put(p, 1'b0);
		cyc(6);
		chk({6'h0, high_side_switch, low_side_switch}, 8'h01);
		chk({4'h0, diagnostic_select_hw}, 8'h0A);
		chk({5'h0, trip_ref_hw}, 8'h05);
		p.drive_in = 1'b1;
		p.diagnostic_select = 3'h0;
		p.trip_level_pin = 3'h5;
		host.put(p, 1'b0);
		for (k = 0; k < 2; k++)
		begin
			sel = (k == 0) ? 2'($urandom % 4) : 2'h3;
			code = 3'($urandom % 7 + 1);
			wr(OFS_CONFIG_THREE, {2'h0, sel, 1'b0, code});
			cyc(211);
			chk({5'h0, trip_reference_sel}, {5'h0, code});
			p.slewing = 1'b1;
			host.put(p, 1'b1);
			cyc(8);
			chk({7'h0, high_side_switch}, 8'h01);
			p.slewing = 1'b0;
			host.put(p, 1'b1);
			wait_hs(1'b0, n);
			chk({7'h0, low_side_switch}, 8'h01);
			if (k == 1)
			begin
				p.drive_in = 1'b0;
				host.put(p, 1'b1);
				cyc(2);
				p.drive_in = 1'b1;
				host.put(p, 1'b1);
			end
			wait_hs(1'b1, n);
			chk(k == 0 ? n : {7'h0, n < 8'd10}, k == 0 ? exp_off(sel) : 8'h01);
			host.put(p, 1'b0);
			rd(OFS_STATUS_ONE, d);
			chk({fault_output_n_oe, d[6:0]}, 8'h09);
		end
		chk({4'h0, diagnostic_select_hw}, 8'h0A);
		chk({5'h0, trip_ref_hw}, 8'h07);
		wr(OFS_COMMAND, 8'h01);
		rd(OFS_STATUS_ONE, d);
		chk(d, 8'h08);
		for (k = 0; k < 2; k++)
		begin
			wr(OFS_CONFIG_TWO, k == 0 ? 8'h02 : 8'h00);
			if (k == 1)
				wr(OFS_CONFIG_THREE, 8'h10);
			cyc(211);
			host.put(p, 1'b1);
			cyc(10);
			chk({7'h0, high_side_switch}, 8'h01);
			host.put(p, 1'b0);
		end
		p.fault_detect = 1'b1;
		host.put(p, 1'b0);
		cyc(6);
		chk({7'h0, fault_output_n_oe}, 8'h01);
		p.fault_detect = 1'b0;
		p.output_disable = 1'b1;
		p.drive_in = 1'b0;
		host.put(p, 1'b0);
		cyc(6);
		chk({6'h0, fault_output_n_oe, high_side_switch}, 8'h02);
		p.sleep_request_n = 1'b0;
		host.put(p, 1'b0);
		cyc(6);
		chk({5'h0, fault_output_n_oe, high_side_switch, low_side_switch}, 8'h00);
		rd(OFS_STATUS_ONE, d);
		chk(d, 8'h00);
		results();
	end

	// Any hang ends the run through the closing report.
	initial
	begin
		#200000;
		error_cnt++;
		$display("mismatch at %0t: run limit reached", $time);
		results();
	end
endmodule

bind ctd_trip_diagnostic_select ctd_trip_diagnostic_select_checker #(.SERIAL_VARIANT(SERIAL_VARIANT),
	.OFF_STEP_CYCLES(OFF_STEP_CYCLES)) chk_i (.mclk, .arst_n, .pins, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .high_side_switch, .low_side_switch, .trip_reference_sel,
	.diagnostic_select_cfg, .fault_output_n_o, .fault_output_n_oe);
